// file: pkg/hpc_link_if.sv
`timescale 1ns/1ps
interface hpc_link_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport cfg
  (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );

  modport dev
  (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );
endinterface

// file: pkg/hpc_pkg.sv
package hpc_pkg;

  // ----------------------------------------------------------------
  // Device register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HPC_OFF_SP_TOTAL_POWER    = 8'h0c;
  localparam logic [7:0] HPC_OFF_BP_TOTAL_POWER    = 8'h0d;
  localparam logic [7:0] HPC_OFF_SP_CTRL_CURRENT   = 8'h0e;
  localparam logic [7:0] HPC_OFF_BP_CTRL_CURRENT   = 8'h0f;
  localparam logic [7:0] HPC_OFF_SETTLE_DELAY      = 8'h10;
  localparam logic [7:0] HPC_OFF_LANG_UPPER        = 8'h11;
  localparam logic [7:0] HPC_OFF_LANG_LOWER        = 8'h12;
  localparam logic [7:0] HPC_OFF_MAKER_LEN         = 8'h13;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] HPC_RST_BP_TOTAL_POWER    = 8'h00;
  localparam logic [7:0] HPC_RST_CTRL_CURRENT      = 8'h32;
  localparam logic [7:0] HPC_RST_SETTLE_DELAY      = 8'h00;
  localparam logic [7:0] HPC_RST_LANG_UPPER        = 8'h00;
  localparam logic [7:0] HPC_RST_LANG_LOWER        = 8'h00;
  localparam logic [7:0] HPC_RST_MAKER_LEN         = 8'h00;

  // ----------------------------------------------------------------
  // Limits checked by the configuring end
  // ----------------------------------------------------------------
  localparam logic [7:0] HPC_SP_LIMIT_UNITS        = 8'h32;
  localparam logic [7:0] HPC_MAKER_LEN_MAX         = 8'h1f;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int         HPC_CLK_KHZ               = 20000;
  localparam int         HPC_SETTLE_STEP_MS        = 2;
  localparam int         HPC_SETTLE_STEP_CYCLES    = HPC_CLK_KHZ * HPC_SETTLE_STEP_MS;

  // ----------------------------------------------------------------
  // Configuring end APB map
  // ----------------------------------------------------------------
  localparam logic [11:0] HPC_APB_CMD              = 12'h000;
  localparam logic [11:0] HPC_APB_STATUS           = 12'h004;
  localparam int          HPC_CMD_ADDR_LSB         = 0;
  localparam int          HPC_CMD_DATA_LSB         = 8;
  localparam int          HPC_CMD_WRITE_BIT        = 16;
  localparam int          HPC_ST_BUSY_BIT          = 0;
  localparam int          HPC_ST_DONE_BIT          = 1;
  localparam int          HPC_ST_REFUSED_BIT       = 2;
  localparam int          HPC_ST_RDATA_LSB         = 8;

endpackage

// file: tb/hpc_link_chk.sv
`timescale 1ns/1ps
module hpc_link_chk
  import hpc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Register link
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_ack,
  input  wire logic [7:0] i_rdata
);
  // ----------------------------------------------------------------
  // Link handshake and limits
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence s_take;
    i_req && !i_ack;
  endsequence

  sequence s_finish;
    i_ack ##1 (!i_ack && !i_req);
  endsequence

  a_take_then_ack: assert property (s_take |=> s_finish)
    else $error("link ack or release late");
  a_ack_has_cause: assert property ($rose(i_ack) |-> $past(i_req && !i_ack))
    else $error("link ack without request");
  a_request_held: assert property (s_take |=> $stable({i_we, i_addr, i_wdata}))
    else $error("link request changed before ack");
  a_rdata_holds: assert property ($changed(i_rdata) |-> $past(i_req && !i_ack && !i_we))
    else $error("link read data changed without read");
  a_unmapped_zero: assert property (s_take ##0
    (!i_we && !(i_addr inside {[HPC_OFF_BP_TOTAL_POWER:HPC_OFF_MAKER_LEN]})) |=> i_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sp_current_cap: assert property (
    s_take ##0 (i_we && i_addr == HPC_OFF_SP_CTRL_CURRENT) |-> i_wdata <= HPC_SP_LIMIT_UNITS)
    else $error("controller current above limit sent");
  a_sp_power_cap: assert property (
    s_take ##0 (i_we && i_addr == HPC_OFF_SP_TOTAL_POWER) |-> i_wdata <= HPC_SP_LIMIT_UNITS)
    else $error("self powered total above limit sent");
  a_maker_len_cap: assert property (
    s_take ##0 (i_we && i_addr == HPC_OFF_MAKER_LEN) |-> i_wdata <= HPC_MAKER_LEN_MAX)
    else $error("maker length above limit sent");
endmodule

// file: tb/test_hub_power_and_language_config.sv
`timescale 1ns/1ps
module test_hub_power_and_language_config;
  import hpc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int STEP = 4;
  logic        clk, nrst, psel, penable, pwrite, self_pw, compound, start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, busy, good, self_o;
  logic [7:0]  sp_total, up_pw, ctrl, emb, settle, mlen;
  logic [8:0]  up_ma, ctrl_ma, settle_ms;
  logic [15:0] lang;
  int          num_errors, num_checks;
  bit   [7:0]  mdl [int];
  hpc_link_if link ();

  hpc_dev #(.STEP_CYCLES(STEP)) i_hpc_dev (.I_CLK(clk), .I_NRST(nrst), .LINK(link), .I_SELF_POWERED(self_pw),
    .I_COMPOUND(compound), .I_SP_TOTAL_POWER(sp_total), .I_PORT_PWR_START(start), .O_PORT_PWR_BUSY(busy),
    .O_PORT_PWR_GOOD(good), .O_UP_MAX_POWER(up_pw), .O_UP_MAX_POWER_MA(up_ma), .O_CTRL_CURRENT(ctrl),
    .O_CTRL_CURRENT_MA(ctrl_ma), .O_EMB_MAX_POWER(emb), .O_SETTLE_DELAY(settle), .O_SETTLE_DELAY_MS(settle_ms),
    .O_LANG_ID(lang), .O_MAKER_LEN(mlen), .O_SELF_POWERED(self_o));
  hpc_cfg i_hpc_cfg (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .LINK(link));
  hpc_link_chk u_chk (.i_clk(clk), .i_nrst(nrst), .i_req(link.req), .i_we(link.we), .i_addr(link.addr),
    .i_wdata(link.wdata), .i_ack(link.ack), .i_rdata(link.rdata));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Idle edge first, so a release and the next setup never share a time step
  // Waits on pready alone; only the watchdog ends a hung access
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", 16'h0000, 16'(pslverr));
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic dev_op(input logic w, input logic [7:0] a, d, output logic [7:0] r, output logic f);
    logic [31:0] s, c;
    c = '0;
    c[HPC_CMD_ADDR_LSB +: 8] = a;
    c[HPC_CMD_DATA_LSB +: 8] = d;
    c[HPC_CMD_WRITE_BIT] = w;
    apb(1'b1, HPC_APB_CMD, c, s);
    do
      apb(1'b0, HPC_APB_STATUS, 32'h0, s);
    while (s[HPC_ST_DONE_BIT] !== 1'b1 && s[HPC_ST_REFUSED_BIT] !== 1'b1);
    r = s[HPC_ST_RDATA_LSB +: 8];
    f = s[HPC_ST_REFUSED_BIT];
    apb(1'b1, HPC_APB_STATUS, 32'((1 << HPC_ST_DONE_BIT) | (1 << HPC_ST_REFUSED_BIT)), s);
  endtask

  // Model keeps the seven mapped bytes; anything else reads zero
  task automatic op_chk(input logic w, input logic [7:0] a, d);
    logic [31:0] s;
    logic [7:0]  r;
    logic        f, ef;
    ef = w && (((a == 8'h0e || a == 8'h0c) && d > 8'h32) || (a == 8'h13 && d > 8'h1f));
    dev_op(w, a, d, r, f);
    chk("refused", 16'(ef), 16'(f));
    if (!ef)
    begin
      apb(1'b0, HPC_APB_CMD, 32'h0, s);
      chk("cmd_readback", {d, a}, s[15:0]);
      chk("cmd_write", 16'(w), 16'(s[16]));
    end
    if (!w)
      chk("read", 16'(mdl.exists(a) ? mdl[a] : 8'h00), 16'(r));
    else if (!ef && mdl.exists(a))
      mdl[a] = d;
  endtask

  task automatic check_desc();
    int bp, cc;
    repeat (5) @(posedge clk);
    #1;
    bp = self_pw ? int'(sp_total) : int'(mdl[8'h0d]);
    cc = self_pw ? int'(mdl[8'h0e]) : int'(mdl[8'h0f]);
    chk("up_power", 16'(bp), 16'(up_pw));
    chk("up_ma", 16'(2 * bp), 16'(up_ma));
    chk("ctrl_current", 16'(cc), 16'(ctrl));
    chk("ctrl_ma", 16'(2 * cc), 16'(ctrl_ma));
    chk("embedded", 16'h0000, 16'(emb));
    chk("settle", 16'(mdl[8'h10]), 16'(settle));
    chk("settle_ms", 16'(2 * mdl[8'h10]), 16'(settle_ms));
    chk("lang", {mdl[8'h11], mdl[8'h12]}, lang);
    chk("maker_len", 16'(mdl[8'h13]), 16'(mlen));
    chk("mode", 16'(self_pw), 16'(self_o));
  endtask

  task automatic do_reset();
    for (int a = 13; a <= 19; a++)
      mdl[a] = 8'h00;
    mdl[8'h0e] = 8'h32;
    mdl[8'h0f] = 8'h32;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    check_desc();
  endtask

  // Count cycles from the start pulse until power is reported good
  task automatic settle_chk(input logic [7:0] n);
    int k;
    op_chk(1'b1, 8'h10, n);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    k = 1;
    chk("settle_busy", 16'(n != 0), 16'(busy));
    while (good !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("settle_cycles", 16'(n * STEP + 1), 16'(k));
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    #500000;
    num_errors++;
    test_done();
  end

  initial
  begin
    logic [31:0] s;
    logic [7:0]  bnd [6][2];
    {psel, penable, pwrite, self_pw, compound, start} = '0;
    paddr = '0; pwdata = '0; sp_total = '0; nrst = 1'b0;
    bnd = '{'{8'h0e, 8'h32}, '{8'h0e, 8'h33}, '{8'h0c, 8'h32}, '{8'h0c, 8'h33}, '{8'h13, 8'h1f}, '{8'h13, 8'h20}};
    void'($urandom(32'h4e266b43));
    do_reset();
    op_chk(1'b0, 8'h0e, 8'h00);
    op_chk(1'b0, 8'h0f, 8'h00);
    for (int i = 0; i < 6; i++)
      op_chk(1'b1, bnd[i][0], bnd[i][1]);
    apb(1'b0, 12'h008, 32'h0, s);
    chk("apb_unmapped", 16'h0000, s[15:0]);
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      // Mode alternates so both powering modes are always reached
      self_pw <= 1'(m);
      compound <= 1'($urandom);
      sp_total <= 8'($urandom);
      repeat (25) op_chk(1'($urandom), 8'h0c + 8'($urandom_range(8)), 8'($urandom_range(64)));
      check_desc();
      if (m == 1)
        do_reset();
    end
    settle_chk(8'h00);
    settle_chk(8'h03);
    test_done();
  end
endmodule

// file: verilog/hpc_cfg.sv
`timescale 1ns/1ps
module hpc_cfg
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_NRST,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Register link
  hpc_link_if.cfg          LINK
);
  import hpc_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_REQ} hpc_cfg_st_t;

  hpc_cfg_st_t st_r;
  logic [7:0]  addr_r;
  logic [7:0]  wdata_r;
  logic        we_r;
  logic        done_r;
  logic        refused_r;
  logic [7:0]  rdata_r;
  logic [31:0] prdata_r;
  logic        apb_wr;
  logic        cmd_wr;
  logic        st_wr;
  logic [7:0]  c_addr;
  logic [7:0]  c_data;
  logic        c_we;
  logic        over;
  logic        launch;
  logic        finish;

  assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
  assign cmd_wr = apb_wr && I_PADDR == HPC_APB_CMD;
  assign st_wr  = apb_wr && I_PADDR == HPC_APB_STATUS;
  assign c_addr = I_PWDATA[HPC_CMD_ADDR_LSB +: 8];
  assign c_data = I_PWDATA[HPC_CMD_DATA_LSB +: 8];
  assign c_we   = I_PWDATA[HPC_CMD_WRITE_BIT];

  // ----------------------------------------------------------------
  // Limit check; board-level content of the figures stays with software
  // ----------------------------------------------------------------
  always_comb
  begin
    over = 1'b0;
    if (c_we && c_addr == HPC_OFF_SP_CTRL_CURRENT)
      over = c_data > HPC_SP_LIMIT_UNITS;
    else if (c_we && c_addr == HPC_OFF_SP_TOTAL_POWER)
      over = c_data > HPC_SP_LIMIT_UNITS;
    else if (c_we && c_addr == HPC_OFF_MAKER_LEN)
      over = c_data > HPC_MAKER_LEN_MAX;
  end

  // Bus-powered total and bus-powered current pass as given by software
  assign launch = cmd_wr && st_r == ST_IDLE && !over;
  assign finish = st_r == ST_REQ && LINK.ack;

  // ----------------------------------------------------------------
  // Link sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      st_r <= ST_IDLE;
    else
      unique case (st_r)
        ST_IDLE: if (launch) st_r <= ST_REQ;
        ST_REQ:  if (LINK.ack) st_r <= ST_IDLE;
      endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      we_r    <= 1'b0;
    end
    else if (launch)
    begin
      addr_r  <= c_addr;
      wdata_r <= c_data;
      we_r    <= c_we;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      rdata_r <= 8'h00;
    else if (finish && !we_r)
      rdata_r <= LINK.rdata;
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      done_r    <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      if (finish)
        done_r <= 1'b1;
      else if (st_wr && I_PWDATA[HPC_ST_DONE_BIT])
        done_r <= 1'b0;
      if (cmd_wr && !launch)
        refused_r <= 1'b1;
      else if (st_wr && I_PWDATA[HPC_ST_REFUSED_BIT])
        refused_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      prdata_r <= 32'h0;
    else if (I_PSEL && !I_PENABLE)
    begin
      prdata_r <= 32'h0;
      if (I_PADDR == HPC_APB_CMD)
        prdata_r <= {15'h0, we_r, wdata_r, addr_r};
      else if (I_PADDR == HPC_APB_STATUS)
        prdata_r <= {16'h0, rdata_r, 5'h0, refused_r, done_r, st_r == ST_REQ};
    end
  end

  assign O_PRDATA   = prdata_r;
  assign O_PREADY   = 1'b1;
  assign O_PSLVERR  = 1'b0;
  assign LINK.req   = st_r == ST_REQ;
  assign LINK.we    = we_r;
  assign LINK.addr  = addr_r;
  assign LINK.wdata = wdata_r;
endmodule

// file: verilog/hpc_dev.sv
// Implementation choice: register access over a req/ack link, driven from APB by hpc_cfg.
`timescale 1ns/1ps
module hpc_dev
#(
  parameter int STEP_CYCLES = hpc_pkg::HPC_SETTLE_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_NRST,
  // Register link
  hpc_link_if.dev         LINK,
  // Hub state
  input  wire logic       I_SELF_POWERED,
  input  wire logic       I_COMPOUND,
  input  wire logic [7:0] I_SP_TOTAL_POWER,
  // Port power sequencing
  input  wire logic       I_PORT_PWR_START,
  output logic            O_PORT_PWR_BUSY,
  output logic            O_PORT_PWR_GOOD,
  // Descriptor values
  output logic [7:0]      O_UP_MAX_POWER,
  output logic [8:0]      O_UP_MAX_POWER_MA,
  output logic [7:0]      O_CTRL_CURRENT,
  output logic [8:0]      O_CTRL_CURRENT_MA,
  output logic [7:0]      O_EMB_MAX_POWER,
  output logic [7:0]      O_SETTLE_DELAY,
  output logic [8:0]      O_SETTLE_DELAY_MS,
  output logic [15:0]     O_LANG_ID,
  output logic [7:0]      O_MAKER_LEN,
  output logic            O_SELF_POWERED
);
  import hpc_pkg::*;

  logic [7:0] bus_powered_total_power_r;
  logic [7:0] self_powered_controller_current_r;
  logic [7:0] bus_powered_controller_current_r;
  logic [7:0] port_power_settle_delay_r;
  logic [7:0] language_code_upper_r;
  logic [7:0] language_code_lower_r;
  logic [7:0] maker_text_char_count_r;

  logic [1:0] self_sync_r;
  logic [1:0] comp_sync_r;
  logic       self_pwr;
  logic       compound;

  logic       ack_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       take;
  logic       wr;

  logic [7:0] up_pwr_r;
  logic [8:0] up_pwr_ma_r;
  logic [7:0] ctrl_cur_r;
  logic [8:0] ctrl_cur_ma_r;
  logic [7:0] emb_pwr_r;
  logic [7:0] settle_r;
  logic [8:0] settle_ms_r;
  logic [15:0] lang_r;
  logic [7:0] maker_r;
  logic       self_out_r;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      self_sync_r <= 2'h0;
      comp_sync_r <= 2'h0;
    end
    else
    begin
      self_sync_r <= {self_sync_r[0], I_SELF_POWERED};
      comp_sync_r <= {comp_sync_r[0], I_COMPOUND};
    end
  end

  assign self_pwr = self_sync_r[1];
  assign compound = comp_sync_r[1];

  // ----------------------------------------------------------------
  // Link handshake: one ack pulse per held request
  // ----------------------------------------------------------------
  assign take = LINK.req && !ack_r;
  assign wr   = take && LINK.we;

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ack_r <= 1'b0;
    else
      ack_r <= take;
  end

  // ----------------------------------------------------------------
  // Register bank
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      bus_powered_total_power_r <= HPC_RST_BP_TOTAL_POWER;
    else if (wr && LINK.addr == HPC_OFF_BP_TOTAL_POWER)
      bus_powered_total_power_r <= LINK.wdata;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      self_powered_controller_current_r <= HPC_RST_CTRL_CURRENT;
    else if (wr && LINK.addr == HPC_OFF_SP_CTRL_CURRENT)
      self_powered_controller_current_r <= LINK.wdata;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      bus_powered_controller_current_r <= HPC_RST_CTRL_CURRENT;
    else if (wr && LINK.addr == HPC_OFF_BP_CTRL_CURRENT)
      bus_powered_controller_current_r <= LINK.wdata;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      port_power_settle_delay_r <= HPC_RST_SETTLE_DELAY;
    else if (wr && LINK.addr == HPC_OFF_SETTLE_DELAY)
      port_power_settle_delay_r <= LINK.wdata;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      language_code_upper_r <= HPC_RST_LANG_UPPER;
      language_code_lower_r <= HPC_RST_LANG_LOWER;
    end
    else if (wr && LINK.addr == HPC_OFF_LANG_UPPER)
      language_code_upper_r <= LINK.wdata;
    else if (wr && LINK.addr == HPC_OFF_LANG_LOWER)
      language_code_lower_r <= LINK.wdata;
  end

  // Stored as written; the length ceiling is the configuring end's job
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      maker_text_char_count_r <= HPC_RST_MAKER_LEN;
    else if (wr && LINK.addr == HPC_OFF_MAKER_LEN)
      maker_text_char_count_r <= LINK.wdata;
  end

  // ----------------------------------------------------------------
  // Read-back; unmapped offsets read zero and drop writes
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (LINK.addr)
      HPC_OFF_BP_TOTAL_POWER:  rdata_nxt = bus_powered_total_power_r;
      HPC_OFF_SP_CTRL_CURRENT: rdata_nxt = self_powered_controller_current_r;
      HPC_OFF_BP_CTRL_CURRENT: rdata_nxt = bus_powered_controller_current_r;
      HPC_OFF_SETTLE_DELAY:    rdata_nxt = port_power_settle_delay_r;
      HPC_OFF_LANG_UPPER:      rdata_nxt = language_code_upper_r;
      HPC_OFF_LANG_LOWER:      rdata_nxt = language_code_lower_r;
      HPC_OFF_MAKER_LEN:       rdata_nxt = maker_text_char_count_r;
      default:                 rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      rdata_r <= 8'h00;
    else if (take && !LINK.we)
      rdata_r <= rdata_nxt;
  end

  assign LINK.ack   = ack_r;
  assign LINK.rdata = rdata_r;

  // ----------------------------------------------------------------
  // Descriptor values; power, current and mode chosen by the present powering mode
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      up_pwr_r      <= 8'h00;
      up_pwr_ma_r   <= 9'h000;
      ctrl_cur_r    <= HPC_RST_CTRL_CURRENT;
      ctrl_cur_ma_r <= {HPC_RST_CTRL_CURRENT, 1'b0};
      self_out_r    <= 1'b0;
    end
    else if (self_pwr)
    begin
      up_pwr_r      <= I_SP_TOTAL_POWER;
      up_pwr_ma_r   <= {I_SP_TOTAL_POWER, 1'b0};
      ctrl_cur_r    <= self_powered_controller_current_r;
      ctrl_cur_ma_r <= {self_powered_controller_current_r, 1'b0};
      self_out_r    <= 1'b1;
    end
    else
    begin
      up_pwr_r      <= bus_powered_total_power_r;
      up_pwr_ma_r   <= {bus_powered_total_power_r, 1'b0};
      ctrl_cur_r    <= bus_powered_controller_current_r;
      ctrl_cur_ma_r <= {bus_powered_controller_current_r, 1'b0};
      self_out_r    <= 1'b0;
    end
  end

  // Embedded function is counted in the hub figure only
  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      emb_pwr_r <= 8'h00;
    else if (compound)
      emb_pwr_r <= 8'h00;
    else
      emb_pwr_r <= 8'h00;
  end

  always_ff @(posedge I_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      settle_r    <= HPC_RST_SETTLE_DELAY;
      settle_ms_r <= 9'h000;
      lang_r      <= 16'h0000;
      maker_r     <= HPC_RST_MAKER_LEN;
    end
    else
    begin
      settle_r    <= port_power_settle_delay_r;
      settle_ms_r <= {port_power_settle_delay_r, 1'b0};
      lang_r      <= {language_code_upper_r, language_code_lower_r};
      maker_r     <= maker_text_char_count_r;
    end
  end

  // ----------------------------------------------------------------
  // Port power settle timing in whole steps
  // ----------------------------------------------------------------
  hpc_settle_timer
  #(
    .STEP_CYCLES (STEP_CYCLES)
  )
  u_settle
  (
    .i_clk   (I_CLK),
    .i_nrst  (I_NRST),
    .i_start (I_PORT_PWR_START),
    .i_steps (port_power_settle_delay_r),
    .o_busy  (O_PORT_PWR_BUSY),
    .o_good  (O_PORT_PWR_GOOD)
  );

  assign O_UP_MAX_POWER    = up_pwr_r;
  assign O_UP_MAX_POWER_MA = up_pwr_ma_r;
  assign O_CTRL_CURRENT    = ctrl_cur_r;
  assign O_CTRL_CURRENT_MA = ctrl_cur_ma_r;
  assign O_EMB_MAX_POWER   = emb_pwr_r;
  assign O_SETTLE_DELAY    = settle_r;
  assign O_SETTLE_DELAY_MS = settle_ms_r;
  assign O_LANG_ID         = lang_r;
  assign O_MAKER_LEN       = maker_r;
  assign O_SELF_POWERED    = self_out_r;
endmodule

// file: verilog/hpc_settle_timer.sv
`timescale 1ns/1ps
module hpc_settle_timer
#(
  parameter int STEP_CYCLES = hpc_pkg::HPC_SETTLE_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Control
  input  wire logic       i_start,
  input  wire logic [7:0] i_steps,
  // Status
  output logic            o_busy,
  output logic            o_good
);
  import hpc_pkg::*;

  logic [31:0] div_r;
  logic [7:0]  left_r;
  logic        busy_r;
  logic        good_r;
  logic        tick;

  // ----------------------------------------------------------------
  // Step divider, restarted with each power-on so steps stay whole
  // ----------------------------------------------------------------
  assign tick = busy_r && (div_r == 32'(STEP_CYCLES - 1));

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      div_r <= 32'h0;
    else if (i_start || tick || !busy_r)
      div_r <= 32'h0;
    else
      div_r <= div_r + 32'h1;
  end

  // ----------------------------------------------------------------
  // Step counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      left_r <= 8'h0;
      busy_r <= 1'b0;
      good_r <= 1'b0;
    end
    else if (i_start)
    begin
      left_r <= i_steps;
      busy_r <= (i_steps != 8'h0);
      good_r <= (i_steps == 8'h0);
    end
    else if (tick)
    begin
      left_r <= left_r - 8'h1;
      if (left_r == 8'h1)
      begin
        busy_r <= 1'b0;
        good_r <= 1'b1;
      end
    end
  end

  assign o_busy = busy_r;
  assign o_good = good_r;
endmodule
